// File: design/sto_monitor.sv
// Safe torque off monitor: dual-channel check, stop sequence, mismatch alarm
//
// Functional notes
// - both inputs low means torque off, isolated
// - stop PWM and gate path within 10ms
// - one low: standby, alarm after 5s
// - both high: normal run with PWM
// - internal alarm forces same emergency stop
// - controlled stop first, then full isolation; the code drops PWM and gate as soon as STO_STOPPING is entered
`timescale 1ns/100ps
`default_nettype none
module sto_monitor
  import sto_pkg::*;
#(
  parameter int unsigned STOP_LEN = STOP_CYCLES,
  parameter int unsigned MISMATCH_LEN = MISMATCH_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Safety channels from pins, active low
  input wire logic safetyInputA_n,
  input wire logic safetyInputB_n,
  // Internal alarm from drive logic
  input wire logic internalAlarm,
  // Drive controls
  output logic pwmEnable,
  output logic stopRequest,
  output logic gateDriveEnable,
  output logic safeTorqueDisable,
  // Status
  output logic mismatchAlarm,
  output logic standby
);
  logic chanA;
  logic chanB;
  sto_state_t state_q;
  sto_state_t state_d;
  logic [CNT_W-1:0] stopCnt_q;
  logic [CNT_W-1:0] mmCnt_q;
  logic mmAlarm_q;
  logic pwm_q;
  logic stopReq_q;
  logic gate_q;
  logic std_q;

  ////////////////////////////////////////////////////////////////////////
  // Synchronise both channels; reset to low for safe start
  sto_sync3 #(.RESET_VAL(1'b0)) uSyncA (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(safetyInputA_n),
    .levelOut(chanA)
  );
  sto_sync3 #(.RESET_VAL(1'b0)) uSyncB (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(safetyInputB_n),
    .levelOut(chanB)
  );

  ////////////////////////////////////////////////////////////////////////
  // Condition decode
  wire bothLow = !chanA && !chanB;
  wire bothHigh = chanA && chanB;
  wire oneLow = chanA ^ chanB;
  wire emergency = bothLow || internalAlarm || mmAlarm_q;
  wire stopDone = (stopCnt_q >= CNT_W'(STOP_LEN - 1));
  wire mmExpire = (mmCnt_q >= CNT_W'(MISMATCH_LEN - 1));

  // Next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      STO_RUN: begin
        if (emergency) begin
          state_d = STO_STOPPING;
        end else if (oneLow) begin
          state_d = STO_STANDBY;
        end
      end
      STO_STANDBY: begin
        if (emergency) begin
          state_d = STO_STOPPING;
        end else if (bothHigh) begin
          state_d = STO_RUN;
        end
      end
      STO_STOPPING: begin
        if (stopDone) begin
          state_d = STO_ISOLATED;
        end
      end
      STO_ISOLATED: begin
        if (bothHigh && !internalAlarm && !mmAlarm_q) begin
          state_d = STO_RUN;
        end
      end
      default: state_d = STO_ISOLATED;
    endcase
  end

  // State register; start isolated until inputs show high
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_q <= STO_ISOLATED;
    end else begin
      state_q <= state_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Controlled stop duration counter
  always_ff @(posedge ref_clk) begin
    if (!rst_n || state_q != STO_STOPPING) begin
      stopCnt_q <= '0;
    end else if (!stopDone) begin
      stopCnt_q <= stopCnt_q + CNT_W'(1);
    end
  end

  // Mismatch timer, cleared on agreement
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !oneLow) begin
      mmCnt_q <= '0;
    end else if (!mmExpire) begin
      mmCnt_q <= mmCnt_q + CNT_W'(1);
    end
  end

  // Sticky mismatch alarm; cleared only when both inputs high again
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      mmAlarm_q <= 1'b0;
    end else if (oneLow && mmExpire) begin
      mmAlarm_q <= 1'b1;
    end else if (bothHigh) begin
      mmAlarm_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output registers from next state
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      pwm_q <= 1'b0;
      stopReq_q <= 1'b0;
      gate_q <= 1'b0;
      std_q <= 1'b0;
    end else begin
      pwm_q <= (state_d == STO_RUN) || (state_d == STO_STANDBY);
      stopReq_q <= (state_d == STO_STOPPING);
      gate_q <= (state_d == STO_RUN) || (state_d == STO_STANDBY);
      std_q <= (state_d == STO_STANDBY);
    end
  end

  assign pwmEnable = pwm_q;
  assign stopRequest = stopReq_q;
  assign gateDriveEnable = gate_q;
  assign safeTorqueDisable = !gate_q;
  assign mismatchAlarm = mmAlarm_q;
  assign standby = std_q;
endmodule
`default_nettype wire

// File: design/sto_pkg.sv
// Package: constants for the safe torque off monitor
package sto_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  // Response limit in microseconds and derived cycle count, rounded down
  localparam int unsigned RESP_LIMIT_US = 10_000;
  localparam int unsigned RESP_CYCLES = (RESP_LIMIT_US * (CLK_HZ / 1_000_000));
  // Controlled stop time budget inside the response limit (cycles)
  localparam int unsigned STOP_CYCLES = RESP_CYCLES / 2;
  // Mismatch wait in seconds and derived count
  localparam int unsigned MISMATCH_S = 5;
  localparam int unsigned MISMATCH_CYCLES = MISMATCH_S * CLK_HZ;
  localparam int CNT_W = 28;
  // Monitor states
  typedef enum logic [1:0] {
    STO_RUN = 2'b00,
    STO_STANDBY = 2'b01,
    STO_STOPPING = 2'b10,
    STO_ISOLATED = 2'b11
  } sto_state_t;
endpackage

// File: design/sto_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module sto_sync3 #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Raw and filtered level
  input wire logic pinIn,
  output logic levelOut
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  wire agree = (s2_q == s3_q);

  // Shift chain; stage one read only by stage two
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s1_q <= RESET_VAL;
      s2_q <= RESET_VAL;
      s3_q <= RESET_VAL;
      level_q <= RESET_VAL;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree) begin
        level_q <= s3_q;
      end
    end
  end

  assign levelOut = level_q;
endmodule
`default_nettype wire

// File: dv/sto_monitor_asserts.sv
// Checker: port timing of the safe torque off monitor
`timescale 1ns/100ps
`default_nettype none
module sto_monitor_asserts (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Inputs
  input wire logic safetyInputA_n,
  input wire logic safetyInputB_n,
  input wire logic internalAlarm,
  // Outputs
  input wire logic pwmEnable,
  input wire logic stopRequest,
  input wire logic gateDriveEnable,
  input wire logic safeTorqueDisable,
  input wire logic mismatchAlarm,
  input wire logic standby
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // Stop path
  tie_inv_a: assert property (safeTorqueDisable != gateDriveEnable) else $error("disable not inverse");
  low_stop_a: assert property ((!safetyInputA_n && !safetyInputB_n) [*6] |-> !gateDriveEnable)
    else $error("gate on with both low");
  alarm_stop_a: assert property (internalAlarm && pwmEnable |=> stopRequest && !pwmEnable && !gateDriveEnable)
    else $error("alarm did not stop");
  stop_first_a: assert property ($fell(stopRequest) |-> !gateDriveEnable && !pwmEnable)
    else $error("run right after stop");
  run_gate_a: assert property (pwmEnable |-> gateDriveEnable && !stopRequest) else $error("run state bad");
  ////////////////////////////////////////////////////////////////////////////////
  // Mismatch path
  mis_stop_a: assert property ($rose(mismatchAlarm) |=> stopRequest) else $error("no stop on mismatch");
  mis_wait_a: assert property ($rose(mismatchAlarm) |-> $past(standby)) else $error("alarm without wait");
endmodule
`default_nettype wire

// File: dv/sto_monitor_tb.sv
// Testbench for the safe torque off monitor
`timescale 1ns/100ps
`default_nettype none
`define CK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_mismatch++; $display("mismatch %s %b %b", nm, e, s); end end
module sto_monitor_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic estop = 1'b0;
  logic alarmIn = 1'b0;
  logic [7:0] skew = 8'h00;
  wire logic chA_n;
  wire logic chB_n;
  wire logic [5:0] obs;
  int n_mismatch = 0;
  int n_tests = 0;
  // Clock
  initial forever #10 ref_clk = ~ref_clk;
  sto_safety_model sto_safety_model_i (.ref_clk(ref_clk), .estop(estop), .skew(skew), .chanA_n(chA_n), .chanB_n(chB_n));
  sto_monitor #(.STOP_LEN(8), .MISMATCH_LEN(20)) sto_monitor_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .safetyInputA_n(chA_n), .safetyInputB_n(chB_n), .internalAlarm(alarmIn), .pwmEnable(obs[5]),
    .stopRequest(obs[4]), .gateDriveEnable(obs[3]), .safeTorqueDisable(obs[2]), .mismatchAlarm(obs[1]),
    .standby(obs[0]));
  // Verdict
  task complete_run;
    $display("counts %0d tests %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Bounded wait for one output bit
  task wt(input int i, input logic v);
    for (int k = 0; k < 100; k++) begin
      if (obs[i] === v) return;
      @(negedge ref_clk);
    end
    n_mismatch++;
    $display("mismatch wait %0d %b %b", i, v, obs[i]);
    complete_run;
  endtask
  // Sequence; vectors are pwm stop gate disable alarm standby
  initial begin
    void'($urandom(6595));
    repeat (20) @(negedge ref_clk);
    `CK("reset", 6'b000100, obs)
    rst_n = 1'b1;
    wt(5, 1'b1);
    `CK("run", 6'b101000, obs)
    skew = 8'($urandom % 3);
    estop = 1'b1;
    wt(5, 1'b0);
    `CK("stopping", 6'b010100, obs)
    wt(4, 1'b0);
    `CK("isolated", 6'b000100, obs)
    $display("test both low done");
    estop = 1'b0;
    wt(5, 1'b1);
    alarmIn = 1'b1;
    @(negedge ref_clk);
    `CK("alarm", 6'b010100, obs)
    alarmIn = 1'b0;
    wt(4, 1'b0);
    wt(5, 1'b1);
    $display("test alarm done");
    skew = 8'hFF;
    estop = 1'b1;
    repeat (10) @(negedge ref_clk);
    `CK("standby", 6'b101001, obs)
    estop = 1'b0;
    repeat (30) @(negedge ref_clk);
    `CK("agree", 6'b101000, obs)
    estop = 1'b1;
    wt(1, 1'b1);
    @(negedge ref_clk);
    `CK("mismatch", 6'b010110, obs)
    estop = 1'b0;
    wt(1, 1'b0);
    $display("test mismatch done");
    complete_run;
  end
endmodule
bind sto_monitor sto_monitor_asserts sto_monitor_asserts_i (.*);
`default_nettype wire

// File: dv/sto_safety_model.sv
// Partner: external safety system driving both channels
`timescale 1ns/100ps
`default_nettype none
module sto_safety_model (
  // Clock
  input wire logic ref_clk,
  // Request and channel B lag in cycles
  input wire logic estop,
  input wire logic [7:0] skew,
  // Channels, active low
  output logic chanA_n,
  output logic chanB_n
);
  int n = 0;
  initial chanA_n = 1'b1;
  initial chanB_n = 1'b1;
  // Channel B follows A after skew + 1 cycles of disagreement.
  // Updated by non-blocking assignment on the rising edge, so the request
  // that the bench sets on the falling edge is read without a race.
  always @(posedge ref_clk) begin
    chanA_n <= !estop;
    n <= (chanA_n == chanB_n) ? 0 : n + 1;
    if (n >= skew) chanB_n <= chanA_n;
  end
endmodule
`default_nettype wire
